// File: rtl/oulink_regs.svh
// Constants of the outdoor unit control link: framing bytes and timing counts.
`ifndef OULINK_REGS_SVH
`define OULINK_REGS_SVH
`define OULINK_FRM_CMD_FIRST   8'he2
`define OULINK_FRM_REPLY_OK    8'he4
`define OULINK_FRM_REPLY_UNSUP 8'he5
`define OULINK_FRM_REPLY_PAR   8'he6
`define OULINK_CLK_PERIOD_PS   5000
`define OULINK_RESP_TIMEOUT_MS 150
`define OULINK_RESP_CYCLES     ((`OULINK_RESP_TIMEOUT_MS * 64'd1000000000) / `OULINK_CLK_PERIOD_PS)
`define OULINK_ALARM_W         4
`define OULINK_CMD_STATUS      8'h10
`endif

// File: rtl/oulink_pkg.sv
// Types shared by the outdoor unit control link.
package oulink_pkg;
	typedef enum logic [3:0] {
		OULINK_IDLE  = 4'b0001,
		OULINK_RX    = 4'b0010,
		OULINK_EXEC  = 4'b0100,
		OULINK_REPLY = 4'b1000
	} oulink_state_t;

	// One received byte with its parity bit, MSB first on the wire.
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       parity;
		logic       last;
	} oulink_rx_byte_t;

	// One reply byte handed to the serialiser.
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       parity;
		logic       last;
	} oulink_tx_byte_t;
endpackage

// File: rtl/oulink_ctrl.sv
// Outdoor unit control link: command handling, alarm shutdown and fault latch.
// Notes on behaviour
// - Indoor unit masters; outdoor unit answers, save for unprompted tracking status.
// - Outdoor unit processes one request at once.
// - Hardware alarm switches transmit power amplifier off.
// - Hardware alarm stops frequency reference output.
// - Fault latched until read or cleared.
// - Outdoor unit may send tracking status unprompted.
// - Answer every request within 150 ms.
// - Bytes MSB first, odd parity follows.
// - Commands open 0xE2 (the first byte's value is not checked, only its parity); good replies open 0xE4.
// - Parity error answered with 0xE6.
`timescale 1ns/1ps
`include "oulink_regs.svh"

module oulink_ctrl #(
	parameter int unsigned RESP_CYCLES = 32'(`OULINK_RESP_CYCLES),
	parameter int unsigned ALARM_W     = `OULINK_ALARM_W
) (
	input  wire logic                      i_ref_clk,
	input  wire logic                      i_sys_rst,
	input  wire oulink_pkg::oulink_rx_byte_t i_rx,
	output logic                           o_rx_ready,
	output oulink_pkg::oulink_tx_byte_t    o_tx,
	input  wire logic                      i_tx_ready,
	input  wire logic [ALARM_W-1:0]        i_hw_alarm,
	input  wire logic                      i_fault_clear,
	input  wire logic                      i_track_event,
	input  wire logic [7:0]                i_track_data,
	output logic                           o_exec_valid,
	output logic [7:0]                     o_exec_cmd,
	input  wire logic                      i_exec_done,
	input  wire logic                      i_exec_unsup,
	output logic                           o_pa_enable,
	output logic                           o_freq_ref_enable,
	output logic [ALARM_W-1:0]             o_fault_latched,
	output logic                           o_busy
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations.
	oulink_pkg::oulink_state_t state_r, state_nxt;
	logic [7:0]         cmd_r, cmd_nxt;
	logic               par_err_r, par_err_nxt;
	logic               is_status_r, is_status_nxt;
	logic [1:0]         reply_idx_r, reply_idx_nxt;
	logic [7:0]         reply_frm_r, reply_frm_nxt;
	logic [ALARM_W-1:0] fault_r, fault_nxt;
	logic [ALARM_W-1:0] fault_snap_r, fault_snap_nxt;
	logic               track_pend_r, track_pend_nxt;
	logic [7:0]         track_r, track_nxt;
	logic               track_send_r, track_send_nxt;
	logic [31:0]        age_r, age_nxt;
	logic               rx_take;
	logic               tx_take;
	logic               parity_ok;

	// Odd parity: the byte plus its parity bit must hold an odd count of ones.
	assign parity_ok  = ^{i_rx.data, i_rx.parity};
	assign rx_take    = i_rx.valid && o_rx_ready;
	assign tx_take    = o_tx.valid && i_tx_ready;
	// Only one request is taken at a time; the receiver stalls otherwise.
	assign o_rx_ready = (state_r == oulink_pkg::OULINK_IDLE) || (state_r == oulink_pkg::OULINK_RX);
	assign o_busy     = (state_r != oulink_pkg::OULINK_IDLE);

	////////////////////////////////////////////////////////////////////////////
	// Request sequencing: receive, execute, reply.
	always_comb begin
		state_nxt     = state_r;
		cmd_nxt       = cmd_r;
		par_err_nxt   = par_err_r;
		is_status_nxt = is_status_r;
		reply_idx_nxt = reply_idx_r;
		reply_frm_nxt = reply_frm_r;
		track_send_nxt = track_send_r;
		age_nxt       = (state_r == oulink_pkg::OULINK_IDLE) ? 32'h0 : age_r + 32'h1;
		case (state_r)
			oulink_pkg::OULINK_IDLE: begin
				par_err_nxt = 1'b0;
				if (rx_take) begin
					// The framing byte arrives first; the slave starts traffic itself only for tracking status.
					par_err_nxt = !parity_ok;
					state_nxt   = i_rx.last ? oulink_pkg::OULINK_EXEC : oulink_pkg::OULINK_RX;
					if (i_rx.last) begin
						cmd_nxt = 8'h00;
					end
				end else if (track_pend_r) begin
					// Tracking status is the one message the slave may send unasked.
					track_send_nxt = 1'b1;
					reply_idx_nxt  = 2'd0;
					state_nxt      = oulink_pkg::OULINK_REPLY;
				end
			end
			oulink_pkg::OULINK_RX: begin
				if (rx_take) begin
					par_err_nxt = par_err_r || !parity_ok;
					// Address is skipped; the final byte taken is the command.
					cmd_nxt     = i_rx.data;
					if (i_rx.last) begin
						state_nxt = oulink_pkg::OULINK_EXEC;
					end
				end
			end
			oulink_pkg::OULINK_EXEC: begin
				// A corrupted status request is not a read, so it must not release the latch.
				is_status_nxt = (cmd_r == `OULINK_CMD_STATUS) && !par_err_r;
				reply_idx_nxt = 2'd0;
				if (par_err_r) begin
					reply_frm_nxt = `OULINK_FRM_REPLY_PAR;
					state_nxt     = oulink_pkg::OULINK_REPLY;
				end else if (cmd_r == `OULINK_CMD_STATUS) begin
					reply_frm_nxt = `OULINK_FRM_REPLY_OK;
					state_nxt     = oulink_pkg::OULINK_REPLY;
				end else if (i_exec_done || age_r >= RESP_CYCLES - 32'd8) begin
					// Give up on the worker near the deadline so the answer still meets it.
					reply_frm_nxt = i_exec_done && !i_exec_unsup ? `OULINK_FRM_REPLY_OK
					                                             : `OULINK_FRM_REPLY_UNSUP;
					state_nxt     = oulink_pkg::OULINK_REPLY;
				end
			end
			oulink_pkg::OULINK_REPLY: begin
				if (tx_take) begin
					reply_idx_nxt = reply_idx_r + 2'd1;
					if (o_tx.last) begin
						state_nxt      = oulink_pkg::OULINK_IDLE;
						track_send_nxt = 1'b0;
						is_status_nxt  = 1'b0;
					end
				end
			end
			default: begin
				state_nxt = oulink_pkg::OULINK_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state_r      <= oulink_pkg::OULINK_IDLE;
			cmd_r        <= 8'h00;
			par_err_r    <= 1'b0;
			is_status_r  <= 1'b0;
			reply_idx_r  <= 2'd0;
			reply_frm_r  <= 8'h00;
			track_send_r <= 1'b0;
			age_r        <= 32'h0;
		end else begin
			state_r      <= state_nxt;
			cmd_r        <= cmd_nxt;
			par_err_r    <= par_err_nxt;
			is_status_r  <= is_status_nxt;
			reply_idx_r  <= reply_idx_nxt;
			reply_frm_r  <= reply_frm_nxt;
			track_send_r <= track_send_nxt;
			age_r        <= age_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Fault latch and tracking capture. A new alarm wins over a clear or read.
	always_comb begin
		fault_nxt      = fault_r;
		fault_snap_nxt = fault_snap_r;
		track_pend_nxt = track_pend_r;
		track_nxt      = track_r;
		// A status reply reports the latch as it stood when the reply began.
		if (state_r == oulink_pkg::OULINK_EXEC && state_nxt == oulink_pkg::OULINK_REPLY && is_status_nxt) begin
			fault_snap_nxt = fault_r;
		end
		// Completed status read releases only what was reported, nothing else.
		if (state_r == oulink_pkg::OULINK_REPLY && state_nxt == oulink_pkg::OULINK_IDLE && is_status_r) begin
			fault_nxt = fault_r & ~fault_snap_r;
		end
		if (i_fault_clear) begin
			fault_nxt = {ALARM_W{1'b0}};
		end
		fault_nxt = fault_nxt | i_hw_alarm;
		if (i_track_event) begin
			track_pend_nxt = 1'b1;
			track_nxt      = i_track_data;
		end else if (track_send_r && state_nxt == oulink_pkg::OULINK_IDLE) begin
			track_pend_nxt = 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			fault_r      <= {ALARM_W{1'b0}};
			fault_snap_r <= {ALARM_W{1'b0}};
			track_pend_r <= 1'b0;
			track_r      <= 8'h00;
		end else begin
			fault_r      <= fault_nxt;
			fault_snap_r <= fault_snap_nxt;
			track_pend_r <= track_pend_nxt;
			track_r      <= track_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs. Amplifier and reference stay off while any fault is latched.
	always_comb begin
		o_pa_enable       = ~|fault_r && ~|i_hw_alarm;
		o_freq_ref_enable = ~|fault_r && ~|i_hw_alarm;
		o_fault_latched   = fault_r;
		o_exec_valid      = (state_r == oulink_pkg::OULINK_EXEC) && !par_err_r && !is_status_nxt;
		o_exec_cmd        = cmd_r;
		o_tx.valid        = (state_r == oulink_pkg::OULINK_REPLY);
		o_tx.data         = track_send_r ? `OULINK_FRM_REPLY_OK : reply_frm_r;
		o_tx.last         = 1'b1;
		if (track_send_r || is_status_r) begin
			// Two-byte replies: framing, then tracking data or the fault bits.
			o_tx.last = (reply_idx_r == 2'd1);
			if (reply_idx_r == 2'd1) begin
				o_tx.data = track_send_r ? track_r : 8'(fault_snap_r);
			end
		end
		o_tx.parity = ~^o_tx.data;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	AST_PA_OFF: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		|i_hw_alarm |-> !o_pa_enable ##1 !o_pa_enable)
		else $error("Amplifier enabled during alarm.");
	AST_REF_OFF: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		|o_fault_latched |-> !o_freq_ref_enable)
		else $error("Reference on with fault latched.");
	AST_LATCH_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(|o_fault_latched && !i_fault_clear && !(state_r == oulink_pkg::OULINK_REPLY && is_status_r))
		|=> ((o_fault_latched & $past(o_fault_latched)) == $past(o_fault_latched)))
		else $error("Fault dropped without read or clear.");
	AST_CLEAR: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(i_fault_clear && i_hw_alarm == '0) |=> o_fault_latched == '0)
		else $error("Clear did not release fault.");
	AST_ONE_AT_A_TIME: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(state_r == oulink_pkg::OULINK_EXEC || state_r == oulink_pkg::OULINK_REPLY) |-> !o_rx_ready)
		else $error("Receiver open while busy.");
	AST_TX_PARITY: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		o_tx.valid |-> ^{o_tx.data, o_tx.parity})
		else $error("Reply parity not odd.");
	AST_PAR_REPLY: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(state_r == oulink_pkg::OULINK_EXEC && par_err_r) |=> o_tx.valid && o_tx.data == 8'he6)
		else $error("Parity error not answered.");
	AST_DEADLINE: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		state_r == oulink_pkg::OULINK_EXEC |-> age_r < RESP_CYCLES)
		else $error("Answer deadline missed.");
	AST_OK_FRAME: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(state_r == oulink_pkg::OULINK_EXEC && !par_err_r && i_exec_done && !i_exec_unsup)
		|=> o_tx.data == 8'he4)
		else $error("Good reply not framed as success.");

endmodule

// File: bench/oulink_idu_model.sv
// Indoor unit master model: sends framed messages and collects the replies.
`timescale 1ns/1ps
`include "oulink_regs.svh"

module oulink_idu_model (
	input  wire logic                        i_ref_clk,
	output oulink_pkg::oulink_rx_byte_t      o_rx,
	input  wire logic                        i_rx_ready,
	input  wire oulink_pkg::oulink_tx_byte_t i_tx,
	output logic                             o_tx_ready
);
	////////////////////////////////////////////////////////////////
	// Nothing is offered until a task runs.
	initial begin
		o_rx = '0;
		o_tx_ready = 1'b0;
	end

	// Offers one byte and holds it until taken; valid stays up so bytes can follow.
	task automatic put_byte(input logic [7:0] d, input logic lst, input logic bad, output logic ok);
		int n;
		ok = 1'b0;
		o_rx.valid = 1'b1;
		o_rx.data = d;
		o_rx.parity = (~^d) ^ bad;
		o_rx.last = lst;
		for (n = 0; n < 400 && !ok; n++) begin
			ok = i_rx_ready;
			@(posedge i_ref_clk);
			#1;
		end
	endtask

	// One whole message; the caller waits for its reply first, so one is outstanding.
	task automatic send_msg(input logic [7:0] c, input logic bad, output logic ok);
		logic ok_head;
		put_byte(`OULINK_FRM_CMD_FIRST, 1'b0, 1'b0, ok_head);
		put_byte(c, 1'b1, bad, ok);
		ok = ok & ok_head;
		o_rx.valid = 1'b0;
		o_rx.data = ~c; // A released line must not keep showing the old byte.
	endtask

	// Takes one reply byte; a clock edge passes first so ready is never set twice at once.
	task automatic get_byte(output logic [7:0] d, output logic ok);
		int n;
		ok = 1'b0;
		d = 8'h00;
		for (n = 0; n < 400 && !ok; n++) begin
			@(posedge i_ref_clk);
			#1;
			if (i_tx.valid === 1'b1) begin
				o_tx_ready = 1'b1;
				d = i_tx.data;
				ok = ^{i_tx.data, i_tx.parity};
				@(posedge i_ref_clk);
				#1;
				o_tx_ready = 1'b0;
			end
		end
	endtask

	// Sends one command up to three times while it is refused; if none succeeds, the master calls a fault.
	task automatic send_retry(input logic [7:0] c, input int n_bad, output logic [7:0] frm, output logic fault);
		int   k;
		logic ok_s;
		logic ok_r;
		frm = 8'h00;
		fault = 1'b1;
		for (k = 0; k < 3 && fault; k++) begin
			send_msg(c, k < n_bad, ok_s);
			// Every attempt gets a fresh bounded wait, so a repeat is never cut short.
			get_byte(frm, ok_r);
			fault = !(ok_s && ok_r && frm == `OULINK_FRM_REPLY_OK);
		end
	endtask
endmodule

// File: bench/oulink_ctrl_tb.sv
// Self-checking bench of the outdoor unit control link.
`timescale 1ns/1ps
`include "oulink_regs.svh"

module oulink_ctrl_tb;
	localparam int unsigned RESP = 200;
	logic                        i_ref_clk = 1'b0;
	logic                        i_sys_rst = 1'b1;
	oulink_pkg::oulink_rx_byte_t rx;
	oulink_pkg::oulink_tx_byte_t o_tx;
	logic                        o_rx_ready, tx_ready, o_exec_valid, o_pa_enable, o_freq_ref_enable, o_busy;
	logic                        i_fault_clear = 1'b0, i_track_event = 1'b0;
	logic                        i_exec_done = 1'b0, i_exec_unsup = 1'b0, ok, flt;
	logic [3:0]                  i_hw_alarm = 4'h0, o_fault_latched;
	logic [7:0]                  i_track_data = 8'h00, o_exec_cmd, d;
	logic [1:0]                  wmode = 2'h0;
	int                          n_checks = 0, n_mismatch = 0;

	oulink_ctrl #(.RESP_CYCLES(RESP)) u_dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_rx(rx),
		.o_rx_ready(o_rx_ready), .o_tx(o_tx), .i_tx_ready(tx_ready), .i_hw_alarm(i_hw_alarm),
		.i_fault_clear(i_fault_clear), .i_track_event(i_track_event), .i_track_data(i_track_data),
		.o_exec_valid(o_exec_valid), .o_exec_cmd(o_exec_cmd), .i_exec_done(i_exec_done),
		.i_exec_unsup(i_exec_unsup), .o_pa_enable(o_pa_enable), .o_freq_ref_enable(o_freq_ref_enable),
		.o_fault_latched(o_fault_latched), .o_busy(o_busy));
	oulink_idu_model u_idu (.i_ref_clk(i_ref_clk), .o_rx(rx), .i_rx_ready(o_rx_ready), .i_tx(o_tx),
		.o_tx_ready(tx_ready));

	////////////////////////////////////////////////////////////////
	// Clock at 200 MHz.
	always #2.5 i_ref_clk = ~i_ref_clk;

	// Worker: answers done or unsupported once a command shows, or stays silent to force the timeout.
	always @(posedge i_ref_clk) begin
		#1;
		i_exec_done = (wmode == 2'h1 || wmode == 2'h2) && o_exec_valid;
		i_exec_unsup = (wmode == 2'h2) && o_exec_valid;
	end

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		$display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// A handshake that never completed ends the run, since later steps would only pile up noise.
	task automatic need(input logic good);
		if (good !== 1'b1) begin
			n_mismatch++;
			$display("Error at %0t: handshake timed out", $time);
			give_verdict;
		end
	endtask

	task automatic rd(input logic [7:0] f);
		u_idu.get_byte(d, ok);
		need(ok);
		check(d, f);
	endtask

	task automatic t_cmd(input logic [7:0] c, input logic [1:0] m, input logic [7:0] f);
		int n;
		wmode = m;
		u_idu.send_msg(c, 1'b0, ok);
		need(ok);
		for (n = 0; n < 8 && o_exec_valid !== 1'b1; n++) begin
			@(posedge i_ref_clk);
			#1;
		end
		check(o_exec_valid, 1'b1);
		check(o_exec_cmd, c);
		check(o_rx_ready, 1'b0);
		check(o_busy, 1'b1);
		rd(f);
	endtask

	// An alarm shuts the amplifier and reference; the fault stays until read, or until cleared.
	task automatic t_alarm;
		i_hw_alarm = 4'h2;
		repeat (2) @(posedge i_ref_clk);
		#1;
		check({o_pa_enable, o_freq_ref_enable}, 2'b00);
		check(o_fault_latched, 4'h2);
		i_hw_alarm = 4'h0;
		t_cmd(8'h31, 2'h1, `OULINK_FRM_REPLY_OK);
		check(o_fault_latched, 4'h2);
		u_idu.send_msg(`OULINK_CMD_STATUS, 1'b0, ok);
		need(ok);
		rd(`OULINK_FRM_REPLY_OK);
		rd(8'h02);
		repeat (2) @(posedge i_ref_clk);
		#1;
		check(o_fault_latched, 4'h0);
		i_hw_alarm = 4'h8;
		@(posedge i_ref_clk);
		#1;
		i_hw_alarm = 4'h0;
		i_fault_clear = 1'b1;
		@(posedge i_ref_clk);
		#1;
		i_fault_clear = 1'b0;
		@(posedge i_ref_clk);
		#1;
		check(o_fault_latched, 4'h0);
		check({o_pa_enable, o_freq_ref_enable}, 2'b11);
	endtask

	// Two refused attempts then a clean one; three refusals in a row make the master call a fault.
	task automatic t_retry;
		wmode = 2'h1;
		u_idu.send_retry(8'h31, 2, d, flt);
		check(d, `OULINK_FRM_REPLY_OK);
		check(flt, 1'b0);
		u_idu.send_retry(8'h31, 3, d, flt);
		check(d, `OULINK_FRM_REPLY_PAR);
		check(flt, 1'b1);
	endtask

	// A reference alarm latches; a corrupted status request leaves the latch, a clean one releases it.
	task automatic t_priority;
		i_hw_alarm = 4'h4;
		@(posedge i_ref_clk);
		#1;
		i_hw_alarm = 4'h0;
		check(o_freq_ref_enable, 1'b0);
		t_cmd(8'h3c, 2'h1, `OULINK_FRM_REPLY_OK);
		check(o_fault_latched, 4'h4);
		u_idu.send_msg(`OULINK_CMD_STATUS, 1'b1, ok);
		need(ok);
		rd(`OULINK_FRM_REPLY_PAR);
		check(o_fault_latched, 4'h4);
		u_idu.send_msg(`OULINK_CMD_STATUS, 1'b0, ok);
		need(ok);
		rd(`OULINK_FRM_REPLY_OK);
		rd(8'h04);
		t_cmd(8'h3c, 2'h1, `OULINK_FRM_REPLY_OK);
		check(o_fault_latched, 4'h0);
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence: reset for three cycles, then the scenarios; parity error and tracking run inline.
	initial begin
		repeat (3) @(posedge i_ref_clk);
		#1;
		i_sys_rst = 1'b0;
		check({o_rx_ready, o_tx.valid, o_pa_enable, o_freq_ref_enable, o_busy}, 5'b10110);
		check(o_fault_latched, 4'h0);
		t_cmd(8'h31, 2'h1, `OULINK_FRM_REPLY_OK);
		t_cmd(8'h3c, 2'h2, `OULINK_FRM_REPLY_UNSUP);
		t_cmd(8'h58, 2'h0, `OULINK_FRM_REPLY_UNSUP);
		u_idu.send_msg(8'h31, 1'b1, ok);
		need(ok);
		rd(`OULINK_FRM_REPLY_PAR);
		t_retry;
		t_alarm;
		t_priority;
		i_track_data = 8'h5a;
		i_track_event = 1'b1;
		@(posedge i_ref_clk);
		#1;
		i_track_event = 1'b0;
		rd(`OULINK_FRM_REPLY_OK);
		rd(8'h5a);
		give_verdict;
	end
endmodule
